// file: inc/pdp_pkg.sv
// Constants, register map and state types of the diagnostic and power block.
// Assumes a 40 MHz system clock and a management clock well below it.
package pdp_pkg;
  // Register addresses on the management interface
  localparam logic [4:0] REG_BASIC   = 5'h00;
  localparam logic [4:0] REG_PLL     = 5'h10;
  localparam logic [4:0] REG_OSC     = 5'h11;
  localparam logic [4:0] REG_DIG     = 5'h16;
  localparam logic [4:0] REG_ENERGY_DETECT_POWER_DOWN    = 5'h18;
  localparam logic [4:0] REG_CABLE   = 5'h1D;
  localparam logic [4:0] REG_PHYCTL2 = 5'h1F;
  // Field positions
  localparam int BASIC_RST_BIT  = 15;
  localparam int BASIC_AN_BIT   = 12;
  localparam int BASIC_PD_BIT   = 11;
  localparam int PLL_AUTO_BIT   = 4;
  localparam int SLOW_OSC_BIT   = 5;
  localparam int NAND_EN_BIT    = 5;
  localparam int ENERGY_DETECT_POWER_DOWN_DIS_BIT   = 11;
  localparam int CT_START_BIT   = 15;
  localparam int MDIX_FORCE_BIT = 14;
  localparam int MDIX_DIS_BIT   = 13;
  localparam int PSAVE_BIT      = 10;
  localparam int CT_DIST_W      = 9;
  // Cable test result codes
  localparam logic [1:0] CT_NORMAL  = 2'h0;
  localparam logic [1:0] CT_OPEN    = 2'h1;
  localparam logic [1:0] CT_SHORT   = 2'h2;
  localparam logic [1:0] CT_INVALID = 2'h3;
  // Reset values
  localparam logic RST_AN       = 1'b1;
  localparam logic RST_ENERGY_DETECT_POWER_DOWN_DIS = 1'b1;
  localparam logic RST_OFF      = 1'b0;
  // Management frame
  localparam logic [5:0] PRE_LEN  = 6'h20;
  localparam logic [5:0] HDR_LEN  = 6'h0D;
  localparam logic [5:0] DATA_LEN = 6'h12;
  localparam logic [1:0] OP_RD    = 2'h2;
  localparam logic [1:0] OP_WR    = 2'h1;
  // Timing
  localparam int CLK_MHZ            = 40;
  localparam int SILENCE_TIMEOUT_US = 1000;
  localparam int LINK_PULSE_US      = 16000;
  localparam int SILENCE_CYC        = SILENCE_TIMEOUT_US * CLK_MHZ;
  localparam int LINK_PULSE_CYC     = LINK_PULSE_US * CLK_MHZ;
  // Board test chain
  localparam int NAND_W = 19;

  typedef enum logic [1:0] {
    PDP_MD_PRE = 2'b00,
    PDP_MD_HDR = 2'b01,
    PDP_MD_RD  = 2'b10,
    PDP_MD_WR  = 2'b11
  } pdp_md_state_e;

  typedef enum logic [1:0] {
    PDP_CT_IDLE    = 2'b00,
    PDP_CT_SILENCE = 2'b01,
    PDP_CT_MEASURE = 2'b10
  } pdp_ct_state_e;
endpackage

// file: core/pdp_diag_power.sv
// Management slave, cable test sequencer, board test chain and power modes.
// Assumes mdc and mdio_in are synchronous to clk; analog front end outside.
`timescale 1ns/100ps
module pdp_diag_power #(
  parameter int unsigned SIL_CYC = pdp_pkg::SILENCE_CYC,
  parameter int unsigned LP_CYC  = pdp_pkg::LINK_PULSE_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic                         mdc,
  input  wire logic                         mdio_in,
  output wire logic                         mdio_out,
  output wire logic                         mdio_oe,
  input  wire logic [2:0]                   phy_addr,
  input  wire logic                         nand_strap_n,
  input  wire logic [pdp_pkg::NAND_W-1:0]   nand_pins,
  input  wire logic                         crs_in,
  output wire logic                         crs_out,
  output wire logic                         nand_mode,
  input  wire logic                         link_up,
  input  wire logic                         auto_mdix_cross,
  input  wire logic                         partner_quiet,
  input  wire logic                         tdr_done,
  input  wire logic [1:0]                   tdr_fault,
  input  wire logic [pdp_pkg::CT_DIST_W-1:0] tdr_count,
  output wire logic                         ct_silence_req,
  output wire logic                         ct_pulse_en,
  output wire logic                         tdr_pair_mdix,
  output logic                              psave_active,
  output logic                              energy_detect_power_down_active,
  output logic                              rx_blocks_off,
  output logic                              pll_off,
  output logic                              tx_off,
  output logic                              energy_det_off,
  output logic                              link_pulse,
  output wire logic                         slow_osc_sel,
  output wire logic                         sw_reset
);
  import pdp_pkg::*;

  function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] r);
    reg_hit = (a == r);
  endfunction

  // Management serial slave
  pdp_md_state_e   md_st_r;
  logic [5:0]      md_cnt_r;
  logic [15:0]     md_sh_r;
  logic [4:0]      md_reg_r;
  logic            mdc_r;
  logic            mdio_out_r;
  logic            mdio_oe_r;
  wire logic       mdc_rise;
  wire logic [12:0] hdr_w;
  wire logic       hdr_ok;
  wire logic [15:0] rd_word;
  wire logic       wr_stb;
  wire logic [15:0] wr_data;

  // Register bits
  logic            an_r;
  logic            pd_r;
  logic            pll_auto_r;
  logic            slow_r;
  logic            nand_en_r;
  logic            energy_detect_power_down_dis_r;
  logic            mdix_force_r;
  logic            mdix_dis_r;
  logic            psave_r;
  logic            soft_rst_r;

  // Cable test
  pdp_ct_state_e   ct_st_r;
  logic [31:0]     ct_cnt_r;
  logic [1:0]      ct_res_r;
  logic [CT_DIST_W-1:0] ct_dist_r;
  logic [31:0]     lp_cnt_r;
  wire logic       ct_busy;
  wire logic       ct_go;
  wire logic       ct_timeout;

  assign mdc_rise = mdc & ~mdc_r;
  assign hdr_w    = {md_sh_r[11:0], mdio_in};
  assign hdr_ok   = hdr_w[12] & (hdr_w[9:8] == 2'h0) &
                    ((hdr_w[7:5] == phy_addr) | (hdr_w[7:5] == 3'h0));
  assign wr_stb   = mdc_rise & (md_st_r == PDP_MD_WR) &
                    (md_cnt_r == DATA_LEN - 6'h01);
  assign wr_data  = {md_sh_r[14:0], mdio_in};
  assign mdio_out = mdio_out_r;
  assign mdio_oe  = mdio_oe_r;

  wire logic wr_basic = wr_stb & reg_hit(md_reg_r, REG_BASIC);
  wire logic wr_pll   = wr_stb & reg_hit(md_reg_r, REG_PLL);
  wire logic wr_osc   = wr_stb & reg_hit(md_reg_r, REG_OSC);
  wire logic wr_dig   = wr_stb & reg_hit(md_reg_r, REG_DIG);
  wire logic wr_energy_detect_power_down  = wr_stb & reg_hit(md_reg_r, REG_ENERGY_DETECT_POWER_DOWN);
  wire logic wr_cable = wr_stb & reg_hit(md_reg_r, REG_CABLE);
  wire logic wr_ctl2  = wr_stb & reg_hit(md_reg_r, REG_PHYCTL2);

  // Read words; unused bits read zero
  wire logic [15:0] rd_basic = (16'(an_r) << BASIC_AN_BIT) |
                               (16'(pd_r) << BASIC_PD_BIT);
  wire logic [15:0] rd_cable = {ct_busy, ct_res_r, 4'h0, ct_dist_r};
  wire logic [15:0] rd_ctl2  = (16'(mdix_force_r) << MDIX_FORCE_BIT) |
                               (16'(mdix_dis_r) << MDIX_DIS_BIT) |
                               (16'(psave_r) << PSAVE_BIT);
  wire logic [4:0]  rd_a     = hdr_w[4:0];
  assign rd_word =
    reg_hit(rd_a, REG_BASIC)   ? rd_basic :
    reg_hit(rd_a, REG_PLL)     ? (16'(pll_auto_r) << PLL_AUTO_BIT) :
    reg_hit(rd_a, REG_OSC)     ? (16'(slow_r) << SLOW_OSC_BIT) :
    reg_hit(rd_a, REG_DIG)     ? (16'(nand_en_r) << NAND_EN_BIT) :
    reg_hit(rd_a, REG_ENERGY_DETECT_POWER_DOWN)    ? (16'(energy_detect_power_down_dis_r) << ENERGY_DETECT_POWER_DOWN_DIS_BIT) :
    reg_hit(rd_a, REG_CABLE)   ? rd_cable :
    reg_hit(rd_a, REG_PHYCTL2) ? rd_ctl2 : 16'h0000;

  // Management stays alive in every power mode; only board test mode stops it
  always_ff @(posedge clk) begin
    mdc_r <= mdc;
    if (!resetn || nand_mode) begin
      md_st_r    <= PDP_MD_PRE;
      md_cnt_r   <= 6'h00;
      md_sh_r    <= 16'h0000;
      md_reg_r   <= 5'h00;
      mdio_out_r <= 1'b0;
      mdio_oe_r  <= 1'b0;
    end else if (mdc_rise) begin
      case (md_st_r)
        PDP_MD_PRE: begin
          if (mdio_in) begin
            md_cnt_r <= (md_cnt_r == PRE_LEN) ? md_cnt_r : md_cnt_r + 6'h01;
          end else if (md_cnt_r == PRE_LEN) begin
            md_st_r  <= PDP_MD_HDR;
            md_cnt_r <= 6'h00;
          end else begin
            md_cnt_r <= 6'h00;
          end
        end
        PDP_MD_HDR: begin
          md_sh_r  <= {md_sh_r[14:0], mdio_in};
          md_cnt_r <= md_cnt_r + 6'h01;
          if (md_cnt_r == HDR_LEN - 6'h01) begin
            md_cnt_r <= 6'h00;
            md_reg_r <= hdr_w[4:0];
            if (hdr_ok && hdr_w[11:10] == OP_RD) begin
              md_st_r <= PDP_MD_RD;
              md_sh_r <= rd_word;
            end else if (hdr_ok && hdr_w[11:10] == OP_WR) begin
              md_st_r <= PDP_MD_WR;
            end else begin
              md_st_r <= PDP_MD_PRE;
            end
          end
        end
        PDP_MD_RD: begin
          md_cnt_r <= md_cnt_r + 6'h01;
          if (md_cnt_r == 6'h00) begin
            mdio_oe_r  <= 1'b1;
            mdio_out_r <= 1'b0;
          end else if (md_cnt_r == DATA_LEN - 6'h01) begin
            mdio_oe_r <= 1'b0;
            md_st_r   <= PDP_MD_PRE;
            md_cnt_r  <= 6'h00;
          end else begin
            mdio_out_r <= md_sh_r[15];
            md_sh_r    <= {md_sh_r[14:0], 1'b0};
          end
        end
        PDP_MD_WR: begin
          md_sh_r  <= wr_data;
          md_cnt_r <= md_cnt_r + 6'h01;
          if (md_cnt_r == DATA_LEN - 6'h01) begin
            md_st_r  <= PDP_MD_PRE;
            md_cnt_r <= 6'h00;
          end
        end
        default: md_st_r <= PDP_MD_PRE;
      endcase
    end
  end

  // Software reset is a one-cycle pulse that restores all defaults
  always_ff @(posedge clk) begin
    if (!resetn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_basic & wr_data[BASIC_RST_BIT];
    end
  end
  assign sw_reset = soft_rst_r;

  always_ff @(posedge clk) begin
    if (!resetn || soft_rst_r) begin
      an_r         <= RST_AN;
      pd_r         <= RST_OFF;
      pll_auto_r   <= RST_OFF;
      slow_r       <= RST_OFF;
      nand_en_r    <= RST_OFF;
      energy_detect_power_down_dis_r   <= RST_ENERGY_DETECT_POWER_DOWN_DIS;
      mdix_force_r <= RST_OFF;
      mdix_dis_r   <= RST_OFF;
      psave_r      <= RST_OFF;
    end else begin
      if (wr_basic) begin
        an_r <= wr_data[BASIC_AN_BIT];
        pd_r <= wr_data[BASIC_PD_BIT];
      end
      if (wr_pll) pll_auto_r <= wr_data[PLL_AUTO_BIT];
      if (wr_osc) slow_r <= wr_data[SLOW_OSC_BIT];
      if (wr_dig) nand_en_r <= wr_data[NAND_EN_BIT];
      if (wr_energy_detect_power_down) energy_detect_power_down_dis_r <= wr_data[ENERGY_DETECT_POWER_DOWN_DIS_BIT];
      if (wr_ctl2) begin
        mdix_force_r <= wr_data[MDIX_FORCE_BIT];
        mdix_dis_r   <= wr_data[MDIX_DIS_BIT];
        psave_r      <= wr_data[PSAVE_BIT];
      end
    end
  end

  // Cable test sequencer; refused while busy or powered down
  assign ct_busy = (ct_st_r != PDP_CT_IDLE);
  assign ct_go   = wr_cable & wr_data[CT_START_BIT] & ~ct_busy & ~pd_r;
  assign ct_timeout = (ct_cnt_r == 32'(SIL_CYC - 1));
  assign ct_silence_req = (ct_st_r == PDP_CT_SILENCE);
  assign ct_pulse_en    = (ct_st_r == PDP_CT_MEASURE);
  assign tdr_pair_mdix  = mdix_dis_r ? mdix_force_r : auto_mdix_cross;

  always_ff @(posedge clk) begin
    if (!resetn || soft_rst_r) begin
      ct_st_r   <= PDP_CT_IDLE;
      ct_cnt_r  <= 32'h0000_0000;
      ct_res_r  <= CT_NORMAL;
      ct_dist_r <= 9'h000;
    end else begin
      case (ct_st_r)
        PDP_CT_IDLE: begin
          ct_cnt_r <= 32'h0000_0000;
          if (ct_go) ct_st_r <= PDP_CT_SILENCE;
        end
        PDP_CT_SILENCE: begin
          ct_cnt_r <= ct_cnt_r + 32'h0000_0001;
          if (partner_quiet) begin
            ct_st_r  <= PDP_CT_MEASURE;
            ct_cnt_r <= 32'h0000_0000;
          end else if (ct_timeout) begin
            ct_st_r   <= PDP_CT_IDLE;
            ct_res_r  <= CT_INVALID;
            ct_dist_r <= 9'h000;
          end
        end
        PDP_CT_MEASURE: begin
          ct_cnt_r <= ct_cnt_r + 32'h0000_0001;
          if (tdr_done) begin
            ct_st_r   <= PDP_CT_IDLE;
            ct_res_r  <= tdr_fault;
            ct_dist_r <= tdr_count;
          end else if (ct_timeout) begin
            ct_st_r   <= PDP_CT_IDLE;
            ct_res_r  <= CT_INVALID;
            ct_dist_r <= 9'h000;
          end
        end
        default: ct_st_r <= PDP_CT_IDLE;
      endcase
    end
  end

  // Board test chain: each low input inverts the running level, so the
  // output toggles on every step of the ordered pull-down
  assign nand_mode = ~nand_strap_n | nand_en_r;
  wire logic [NAND_W:0] chain;
  assign chain[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 0; gi < NAND_W; gi++) begin : g_chain
      assign chain[gi+1] = chain[gi] ~^ nand_pins[gi];
    end
  endgenerate
  assign crs_out = nand_mode ? chain[NAND_W] : crs_in;

  // Power modes
  wire logic no_link  = an_r & ~link_up & ~pd_r;
  wire logic ps_nxt   = psave_r & no_link;
  wire logic ed_nxt   = ~energy_detect_power_down_dis_r & no_link;
  assign slow_osc_sel = slow_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      psave_active   <= 1'b0;
      energy_detect_power_down_active    <= 1'b0;
      rx_blocks_off  <= 1'b0;
      pll_off        <= 1'b0;
      tx_off         <= 1'b0;
      energy_det_off <= 1'b0;
      link_pulse     <= 1'b0;
      lp_cnt_r       <= 32'h0000_0000;
    end else begin
      psave_active   <= ps_nxt;
      energy_detect_power_down_active    <= ed_nxt;
      rx_blocks_off  <= pd_r | ps_nxt | ed_nxt;
      pll_off        <= pd_r | (ed_nxt & pll_auto_r);
      tx_off         <= pd_r;
      energy_det_off <= pd_r;
      // Longer LP_CYC saves power but slows wake-up
      if (!energy_detect_power_down_active) begin
        lp_cnt_r   <= 32'h0000_0000;
        link_pulse <= 1'b0;
      end else begin
        link_pulse <= (lp_cnt_r == 32'(LP_CYC - 1));
        lp_cnt_r   <= (lp_cnt_r == 32'(LP_CYC - 1)) ? 32'h0000_0000
                                                    : lp_cnt_r + 32'h0000_0001;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_ct_start;
    ct_go |=> ct_busy ##1 ct_busy;
  endproperty
  a_ct_start: assert property (p_ct_start) else $error("test not started");

  property p_ct_done;
    (ct_st_r == PDP_CT_MEASURE && tdr_done && !soft_rst_r) |=>
      (!ct_busy && ct_res_r == $past(tdr_fault) &&
       ct_dist_r == $past(tdr_count));
  endproperty
  a_ct_done: assert property (p_ct_done) else $error("result not taken");

  property p_ct_invalid;
    (ct_st_r == PDP_CT_SILENCE && !partner_quiet && ct_timeout &&
     !soft_rst_r) |=> (ct_res_r == CT_INVALID && !ct_busy);
  endproperty
  a_ct_invalid: assert property (p_ct_invalid) else $error("no code 11");

  property p_ct_hold;
    (!ct_busy && !ct_go && !soft_rst_r) |=>
      ($stable(ct_res_r) && $stable(ct_dist_r));
  endproperty
  a_ct_hold: assert property (p_ct_hold) else $error("result drifted");

  property p_nand_on;
    (wr_dig && wr_data[NAND_EN_BIT]) |=> nand_mode;
  endproperty
  a_nand_on: assert property (p_nand_on) else $error("chain not entered");

  property p_nand_toggle;
    (nand_mode && $past(nand_mode) &&
     $countones(nand_pins ^ $past(nand_pins)) == 1) |->
      (crs_out != $past(crs_out));
  endproperty
  a_nand_toggle: assert property (p_nand_toggle) else $error("no toggle");

  property p_psave;
    psave_active |-> $past(psave_r && an_r && !link_up && !pd_r);
  endproperty
  a_psave: assert property (p_psave) else $error("bad power saving");

  property p_pll;
    (energy_detect_power_down_active && $past(pll_auto_r)) |-> pll_off;
  endproperty
  a_pll: assert property (p_pll) else $error("PLL left running");

  property p_pd;
    (pd_r && !soft_rst_r) |=>
      (tx_off && rx_blocks_off && pll_off && energy_det_off);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down incomplete");

  property p_lp;
    link_pulse |-> $past(energy_detect_power_down_active);
  endproperty
  a_lp: assert property (p_lp) else $error("stray link pulse");

  c_ct_run:   cover property (ct_go ##[1:1000] (tdr_done && ct_pulse_en));
  c_ct_inv:   cover property (ct_timeout && ct_silence_req);
  c_nand:     cover property (nand_mode ##1 (crs_out != $past(crs_out)));
  c_lowest:   cover property (pd_r && slow_r);
endmodule // pdp_diag_power

// file: tb/pdp_mdio_master.sv
// Management station model: clause 22 frames on mdc and the shared data line.
// Assumes a clk fast enough to make mdc at a quarter of its rate.
`timescale 1ns/100ps
module pdp_mdio_master (
  input  wire logic clk,
  output logic      mdc,
  output wire logic mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic drv_en;
  logic drv_bit;

  // Pull-up holds the line high when nobody drives it
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_bit : 1'b1);

  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_bit = 1'b1;
  end

  // Data changes while mdc is low, device samples at the rise
  task automatic clk_bit(input logic b, input logic en);
    @(posedge clk);
    mdc     <= 1'b0;
    drv_en  <= en;
    drv_bit <= b;
    repeat (2) @(posedge clk);
    mdc <= 1'b1;
    @(posedge clk);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    hdr = {2'b01, op, pa, ra};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) clk_bit(hdr[i], 1'b1);
    if (op == pdp_pkg::OP_WR) begin
      clk_bit(1'b1, 1'b1);
      clk_bit(1'b0, 1'b1);
      for (int i = 15; i >= 0; i--) clk_bit(wd[i], 1'b1);
    end else begin
      // Line released at turnaround, slave takes over
      clk_bit(1'b1, 1'b0);
      clk_bit(1'b1, 1'b0);
      // Slave drives each bit after the rise before it; sample, then clock
      for (int i = 15; i >= 0; i--) begin
        @(negedge clk);
        rd[i] = mdio_in;
        clk_bit(1'b1, 1'b0);
      end
    end
    clk_bit(1'b1, 1'b0);
    repeat (4) @(posedge clk);
  endtask
endmodule // pdp_mdio_master

// file: tb/testbench.sv
// Self-checking bench for the diagnostic and power block.
// Assumes the management station model in pdp_mdio_master.
`timescale 1ns/100ps
module testbench;
  import pdp_pkg::*;
  localparam int unsigned SIL = 400;
  localparam int unsigned LP  = 16;
  localparam logic [2:0]  ADDR = 3'h5;
  logic        clk, resetn, nand_strap_n, crs_in, link_up, auto_mdix_cross;
  logic        partner_quiet, tdr_done;
  logic [18:0] nand_pins;
  logic [1:0]  tdr_fault;
  logic [8:0]  tdr_count;
  logic [15:0] lp_cnt, sw_cnt, v;
  int          num_errors, checked;
  wire logic   mdc, mdio_in, mdio_out, mdio_oe, crs_out, nand_mode;
  wire logic   ct_silence_req, ct_pulse_en, tdr_pair_mdix, psave_active;
  wire logic   energy_detect_power_down_active, rx_blocks_off, pll_off, tx_off, energy_det_off;
  wire logic   link_pulse, slow_osc_sel, sw_reset;

  pdp_diag_power #(.SIL_CYC(SIL), .LP_CYC(LP)) i_pdp_diag_power (
    .clk, .resetn, .mdc, .mdio_in, .mdio_out, .mdio_oe, .phy_addr(ADDR),
    .nand_strap_n, .nand_pins, .crs_in, .crs_out, .nand_mode, .link_up,
    .auto_mdix_cross, .partner_quiet, .tdr_done, .tdr_fault, .tdr_count,
    .ct_silence_req, .ct_pulse_en, .tdr_pair_mdix, .psave_active,
    .energy_detect_power_down_active, .rx_blocks_off, .pll_off, .tx_off, .energy_det_off,
    .link_pulse, .slow_osc_sel, .sw_reset);

  pdp_mdio_master i_pdp_mdio_master (
    .clk, .mdc, .mdio_in, .mdio_out, .mdio_oe);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (link_pulse === 1'b1) lp_cnt <= lp_cnt + 16'h0001;
    if (sw_reset === 1'b1) sw_cnt <= sw_cnt + 16'h0001;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    i_pdp_mdio_master.frame(OP_WR, {2'b00, ADDR}, ra, d, x);
  endtask

  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    i_pdp_mdio_master.frame(OP_RD, {2'b00, ADDR}, ra, 16'h0000, d);
  endtask

  // Registered power outputs lag their cause by one cycle
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_defaults;
    rd(REG_BASIC, v);
    chk(v, 16'h1000);
    rd(REG_ENERGY_DETECT_POWER_DOWN, v);
    chk(v, 16'h0800);
    rd(5'h05, v);
    chk(v, 16'h0000);
    chk(psave_active, 16'h0000);
  endtask

  task automatic t_cable;
    wr(REG_PHYCTL2, 16'h6000);
    chk(tdr_pair_mdix, 16'h0001);
    wr(REG_PHYCTL2, 16'h2000);
    chk(tdr_pair_mdix, 16'h0000);
    // Frame for another station must be ignored
    i_pdp_mdio_master.frame(OP_WR, 5'h06, REG_PHYCTL2, 16'h0000, v);
    rd(REG_PHYCTL2, v);
    chk(v, 16'h2000);
    @(posedge clk);
    partner_quiet <= 1'b0;
    tdr_count <= 9'h1FF;
    wr(REG_CABLE, 16'h8000);
    chk(ct_silence_req, 16'h0001);
    chk(ct_pulse_en, 16'h0000);
    rd(REG_CABLE, v);
    chk(v[15], 16'h0001);
    rd(REG_CABLE, v);
    chk(v, 16'h6000);
    for (int f = 0; f < 3; f++) begin
      @(posedge clk);
      partner_quiet <= 1'b1;
      tdr_fault <= f[1:0];
      tdr_count <= 9'h0A5 + 9'(f);
      wr(REG_CABLE, 16'h8000);
      rd(REG_CABLE, v);
      chk(v, {1'b0, f[1:0], 4'h0, 9'h0A5 + 9'(f)});
    end
    @(posedge clk);
    tdr_count <= 9'h000;
    tdr_fault <= CT_NORMAL;
    rd(REG_CABLE, v);
    chk(v, 16'h40A7);
  endtask

  task automatic t_power;
    wr(REG_PHYCTL2, 16'h0400);
    settle;
    chk({psave_active, rx_blocks_off, pll_off, tx_off}, 16'h000C);
    @(posedge clk);
    link_up <= 1'b1;
    settle;
    chk(psave_active, 16'h0000);
    @(posedge clk);
    link_up <= 1'b0;
    wr(REG_ENERGY_DETECT_POWER_DOWN, 16'h0000);
    settle;
    chk({energy_detect_power_down_active, pll_off}, 16'h0002);
    wr(REG_PLL, 16'h0010);
    settle;
    chk({pll_off, tx_off, energy_det_off}, 16'h0004);
    lp_cnt = 16'h0000;
    repeat (2 * LP) @(negedge clk);
    chk(lp_cnt, 16'h0002);
    wr(REG_BASIC, 16'h1800);
    settle;
    chk({tx_off, energy_det_off, pll_off, energy_detect_power_down_active}, 16'h000E);
    wr(REG_OSC, 16'h0020);
    settle;
    chk(slow_osc_sel, 16'h0001);
    rd(REG_OSC, v);
    chk(v, 16'h0020);
    wr(REG_OSC, 16'h0000);
    wr(REG_BASIC, 16'h1000);
    settle;
    chk({slow_osc_sel, tx_off}, 16'h0000);
    wr(REG_BASIC, 16'h9000);
    settle;
    chk(sw_cnt, 16'h0001);
    rd(REG_ENERGY_DETECT_POWER_DOWN, v);
    chk(v, 16'h0800);
    chk({energy_detect_power_down_active, psave_active}, 16'h0000);
  endtask

  task automatic t_nand;
    @(posedge clk);
    nand_pins <= '1;
    nand_strap_n <= 1'b0;
    settle;
    chk({nand_mode, crs_out}, 16'h0003);
    for (int k = 0; k < NAND_W; k++) begin
      @(posedge clk);
      nand_pins[k] <= 1'b0;
      settle;
      chk(crs_out, {15'h0000, k[0]});
    end
    @(posedge clk);
    nand_strap_n <= 1'b1;
    settle;
    chk({nand_mode, crs_out}, 16'h0001);
    wr(REG_DIG, 16'h0020);
    settle;
    chk(nand_mode, 16'h0001);
    // Slave is idle in test mode, only a hard reset leaves it
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    settle;
    chk(nand_mode, 16'h0000);
  endtask

  task automatic summarize;
    $display("Errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    summarize;
  end

  initial begin
    num_errors = 0;
    checked = 0;
    lp_cnt = 16'h0000;
    sw_cnt = 16'h0000;
    resetn = 1'b0;
    nand_strap_n = 1'b1;
    nand_pins = '1;
    crs_in = 1'b1;
    link_up = 1'b0;
    auto_mdix_cross = 1'b1;
    partner_quiet = 1'b0;
    tdr_done = 1'b1;
    tdr_fault = CT_NORMAL;
    tdr_count = 9'h000;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_defaults;
    t_cable;
    t_power;
    t_nand;
    summarize;
  end
endmodule // testbench
